// ===== logic/asrc_params.svh
// constants for the stereo sample rate converter core
// assumes a 200 MHz master clock; included by bare name
`ifndef ASRC_PARAMS_SVH
`define ASRC_PARAMS_SVH
`define ASRC_FRAC_BITS      20
`define ASRC_BASE_TAPS      64
`define ASRC_BUF_DEPTH      512
`define ASRC_MIN_LEAD       16
`define ASRC_GDLY_BITS      7
`define ASRC_DATA_W         24
`define ASRC_COEF_W         18
`define ASRC_COEF_STORE_LOG 4
`define ASRC_FIFO_DEPTH     16
`define ASRC_AVG_SHIFT      4
`define ASRC_SETTLE_LIMIT   8
`define ASRC_MAX_DECIM      7
`define ASRC_CLK_PS         5000
`define ASRC_RES_PS         4.96
`define ASRC_SETTLE_FAST    16'h0040
`endif

// ===== logic/asrc_pkg.sv
// types shared by the sample rate converter core
// assumes asrc_params.svh is on the include path
`include "asrc_params.svh"
package asrc_pkg;
	typedef enum logic [1:0] {
		ASRC_IDLE,
		ASRC_LEFT,
		ASRC_RIGHT,
		ASRC_DONE
	} asrc_state_e;
	typedef logic [`ASRC_DATA_W-1:0] asrc_word_t;
endpackage

// ===== logic/asrc_fifo.sv
// small synchronous fifo with valid/ready on both sides, registered read data
// assumes a single clock and synchronous active-high reset
`timescale 1ns/1ps
`include "asrc_params.svh"
module asrc_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = `ASRC_FIFO_DEPTH
) (
	input  wire logic             i_clk,
	input  wire logic             i_srst,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("asrc_fifo depth must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_reg;
	logic [AW:0]      rd_reg;
	logic             oval_reg;
	wire  [AW:0]      level    = wr_reg - rd_reg;
	wire              empty    = (level == '0);
	wire              full     = level[AW];
	wire              pop      = !empty && (!oval_reg || i_out_ready);
	wire              push     = i_in_valid && !full;
	assign o_in_ready  = !full;
	assign o_out_valid = oval_reg;
	always_ff @(posedge i_clk) begin
		if (push)
			mem[wr_reg[AW-1:0]] <= i_in_data;
		if (pop)
			o_out_data <= mem[rd_reg[AW-1:0]];
	end
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			wr_reg   <= '0;
			rd_reg   <= '0;
			oval_reg <= 1'b0;
		end else begin
			if (push)
				wr_reg <= wr_reg + 1'b1;
			if (pop)
				rd_reg <= rd_reg + 1'b1;
			if (pop)
				oval_reg <= 1'b1;
			else if (i_out_ready)
				oval_reg <= 1'b0;
		end
	end
endmodule

// ===== logic/asrc_core.sv
// stereo asynchronous sample rate converter datapath
// assumes input and output rate strobes are one-cycle pulses synchronous to i_clk
// Summary of operation
// - behave like 2^20 zero-stuffed upsampling followed by low-pass filtering
// - output takes nearest fine-grid interpolated value, not nearest input
// - one convolution per output sample period only
// - upsampling uses a 64-tap filter at the chosen polyphase position
// - output instant estimated finely by averaging coarse period measurements
// - store keeps coefficient subset; intermediate phases interpolated
// - when decimating scale store start address, input amplitude, length
// - decimating stretches coefficients; length grows by input/output ratio
// - largest decimation bounded by sample buffer depth
// - sample buffer holds 512 words per channel
// - write leads read by 16 plus seven-bit group delay
// - buffer address steps down one per tap; phase steps; ends on wrap
// - fast settling mode raises the click warning flag
`timescale 1ns/1ps
`include "asrc_params.svh"
module asrc_core #(
	parameter int DATA_W   = `ASRC_DATA_W,
	parameter int BUF_D    = `ASRC_BUF_DEPTH,
	parameter int MAXDEC   = `ASRC_MAX_DECIM
) (
	input  wire logic                       i_clk,
	input  wire logic                       i_srst,
	input  wire logic                       i_in_valid,
	output logic                            o_in_ready,
	input  wire asrc_pkg::asrc_word_t       i_in_left,
	input  wire asrc_pkg::asrc_word_t       i_in_right,
	input  wire logic                       i_out_strobe,
	input  wire logic [`ASRC_GDLY_BITS-1:0] i_group_delay,
	output asrc_pkg::asrc_word_t            o_out_left,
	output asrc_pkg::asrc_word_t            o_out_right,
	output logic                            o_out_valid,
	output logic                            o_servo_settling_flag
);
	import asrc_pkg::*;
	localparam int AW = $clog2(BUF_D);
	localparam int FB = `ASRC_FRAC_BITS;
	localparam int CW = `ASRC_COEF_W;
	localparam int SL = `ASRC_COEF_STORE_LOG;
	localparam int ACC_W = DATA_W + CW + 10;
	initial begin
		if (DATA_W != `ASRC_DATA_W || (1 << AW) != BUF_D)
			$error("asrc_core needs a power-of-two buffer and the package word width");
		if (MAXDEC * `ASRC_BASE_TAPS > BUF_D - `ASRC_MIN_LEAD)
			$error("asrc_core decimation limit exceeds buffer history");
	end
	// coefficient store: triangular window subset, one entry per tap-phase knot
	function automatic logic signed [CW-1:0] coef_knot(input logic [SL+6:0] k);
		logic [SL+5:0] d;
		d = k[SL+6] ? ~k[SL+5:0] : k[SL+5:0];
		// non-negative window keeps the low-pass dc gain positive
		coef_knot = CW'({1'b0, d, 7'h00});
	endfunction
	// linear blend between neighbouring knots yields any phase
	function automatic logic signed [CW-1:0] coef_at(input logic [FB+6:0] pos);
		logic signed [CW+FB:0] a;
		logic signed [CW+FB:0] b;
		logic [FB-SL-1:0]      f;
		a = coef_knot(pos[FB+6:FB-SL]);
		b = coef_knot(pos[FB+6:FB-SL] + 1'b1);
		f = pos[FB-SL-1:0];
		coef_at = CW'((a * (2**(FB-SL) - f) + b * f) >>> (FB - SL));
	endfunction
	function automatic asrc_word_t sat(input logic signed [ACC_W-1:0] v);
		logic signed [ACC_W-1:0] s;
		s = v >>> (CW - 1);
		if (s > ACC_W'(2**(DATA_W-1) - 1))
			sat = {1'b0, {(DATA_W-1){1'b1}}};
		else if (s < -ACC_W'(2**(DATA_W-1)))
			sat = {1'b1, {(DATA_W-1){1'b0}}};
		else
			sat = s[DATA_W-1:0];
	endfunction

	// input fifo decouples the producer from buffer writes during convolution
	logic [2*DATA_W-1:0] fifo_data;
	logic                fifo_valid;
	asrc_state_e         st_reg;
	wire                 fifo_take = fifo_valid && (st_reg == ASRC_IDLE);
	asrc_fifo #(.WIDTH(2*DATA_W), .DEPTH(`ASRC_FIFO_DEPTH)) u_fifo (
		.i_clk       (i_clk),
		.i_srst      (i_srst),
		.i_in_valid  (i_in_valid),
		.o_in_ready  (o_in_ready),
		.i_in_data   ({i_in_left, i_in_right}),
		.o_out_valid (fifo_valid),
		.i_out_ready (fifo_take),
		.o_out_data  (fifo_data)
	);

	// rate measurement: period counters averaged by a first-order filter
	logic [15:0] in_cnt_reg, in_per_reg, out_cnt_reg, out_per_reg;
	logic [23:0] step_reg;      // output period in fine grid units of the input period
	logic [3:0]  settle_reg;
	logic        fast_reg;
	// arrivals, not drains: drain timing jitters with engine load
	wire         in_evt  = i_in_valid && o_in_ready;
	wire         decim   = out_per_reg > in_per_reg;
	// ratio in_rate/out_rate as integer stretch, bounded by buffer history
	wire  [15:0] ratio_raw = (in_per_reg == 16'h0000) ? 16'h0001 : out_per_reg / in_per_reg;
	wire  [3:0]  stretch   = !decim ? 4'h1 : (ratio_raw > 16'(MAXDEC)) ? 4'(MAXDEC) :
	                         (ratio_raw == 16'h0000) ? 4'h1 : ratio_raw[3:0];
	wire  [FB:0] ph_step   = (FB+1)'((1 << FB) / stretch);
	wire  [23:0] step_meas = (in_per_reg == 16'h0000) ? 24'h100000 :
	                         24'(({20'h00000, out_per_reg} << FB) / in_per_reg);
	wire  [24:0] step_diff = {1'b0, step_meas} - {1'b0, step_reg};
	wire  [4:0]  avg_sh    = fast_reg ? 5'h1 : 5'(`ASRC_AVG_SHIFT);
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			in_cnt_reg  <= '0;
			in_per_reg  <= '0;
			out_cnt_reg <= '0;
			out_per_reg <= '0;
			step_reg    <= 24'h100000;
			fast_reg    <= 1'b1;
			settle_reg  <= '0;
		end else begin
			in_cnt_reg  <= in_evt ? 16'h0001 : in_cnt_reg + 1'b1;
			out_cnt_reg <= i_out_strobe ? 16'h0001 : out_cnt_reg + 1'b1;
			if (in_evt)
				in_per_reg <= in_cnt_reg;
			if (i_out_strobe) begin
				out_per_reg <= out_cnt_reg;
				step_reg <= step_reg + 24'($signed(step_diff) >>> avg_sh);
				if (step_diff[24:8] == '0 || step_diff[24:8] == '1) begin
					if (settle_reg == 4'(`ASRC_SETTLE_LIMIT))
						fast_reg <= 1'b0;
					else
						settle_reg <= settle_reg + 1'b1;
				end else begin
					settle_reg <= '0;
					fast_reg   <= 1'b1;
				end
			end
		end
	end
	assign o_servo_settling_flag = fast_reg;

	// ramp: integer part is buffer position, fraction is fine grid phase
	logic [AW+FB-1:0] ramp_reg;
	logic [AW-1:0]    wr_reg;
	wire  [AW-1:0]    lead = AW'(`ASRC_MIN_LEAD) + AW'(i_group_delay);
	wire  [AW-1:0]    ram_start = wr_reg - lead;
	always_ff @(posedge i_clk) begin
		if (i_srst)
			ramp_reg <= '0;
		else if (i_out_strobe)
			ramp_reg <= {ram_start, ramp_reg[FB-1:0]} + (AW+FB)'(step_reg);
	end

	// sample buffers, input scaled down by out/in when decimating
	logic signed [DATA_W-1:0] buf_l [BUF_D];
	logic signed [DATA_W-1:0] buf_r [BUF_D];
	wire  signed [DATA_W-1:0] in_l = fifo_data[2*DATA_W-1:DATA_W];
	wire  signed [DATA_W-1:0] in_r = fifo_data[DATA_W-1:0];
	wire  signed [DATA_W+4:0] sc_l = (DATA_W+5)'(in_l / $signed({1'b0, stretch}));
	wire  signed [DATA_W+4:0] sc_r = (DATA_W+5)'(in_r / $signed({1'b0, stretch}));
	always_ff @(posedge i_clk) begin
		if (fifo_take) begin
			buf_l[wr_reg] <= sc_l[DATA_W-1:0];
			buf_r[wr_reg] <= sc_r[DATA_W-1:0];
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_srst)
			wr_reg <= '0;
		else if (fifo_take)
			wr_reg <= wr_reg + 1'b1;
	end

	// convolution engine: one pass per output strobe, one multiplier per channel sharing the coefficient
	logic [AW-1:0]          raddr_reg;
	logic [FB+6:0]          ph_reg;
	logic signed [ACC_W-1:0] acc_l_reg, acc_r_reg;
	logic                   pend_reg;
	// start phase scaled by stretch so the coefficient curve widens
	wire  [FB+6:0]  ph_start = (FB+7)'(ramp_reg[FB-1:0] / stretch);
	wire  [FB+7:0]  ph_sum   = {1'b0, ph_reg} + (FB+8)'(ph_step);
	// 64 unit phase steps span the curve, so wrap at 2^(FB+6)
	wire            ph_wrap  = ph_sum[FB+6];
	wire  signed [CW-1:0] coef = coef_at({ph_reg[FB+5:0], 1'b0});
	wire  signed [ACC_W-1:0] prod_l = ACC_W'(buf_l[raddr_reg]) * ACC_W'(coef);
	wire  signed [ACC_W-1:0] prod_r = ACC_W'(buf_r[raddr_reg]) * ACC_W'(coef);
	asrc_state_e st_next;
	always_comb begin
		case (st_reg)
			ASRC_IDLE:  st_next = pend_reg && !fifo_valid ? ASRC_LEFT : ASRC_IDLE;
			ASRC_LEFT:  st_next = ph_wrap ? ASRC_DONE : ASRC_LEFT;
			ASRC_RIGHT: st_next = ASRC_DONE;
			ASRC_DONE:  st_next = ASRC_IDLE;
			default:    st_next = ASRC_IDLE;
		endcase
	end
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st_reg      <= ASRC_IDLE;
			pend_reg    <= 1'b0;
			raddr_reg   <= '0;
			ph_reg      <= '0;
			acc_l_reg   <= '0;
			acc_r_reg   <= '0;
			o_out_left  <= '0;
			o_out_right <= '0;
			o_out_valid <= 1'b0;
		end else begin
			st_reg      <= st_next;
			o_out_valid <= 1'b0;
			if (i_out_strobe)
				pend_reg <= 1'b1;
			case (st_reg)
				ASRC_IDLE: begin
					if (st_next == ASRC_LEFT) begin
						pend_reg  <= i_out_strobe;
						raddr_reg <= ramp_reg[AW+FB-1:FB];
						ph_reg    <= ph_start;
						acc_l_reg <= '0;
						acc_r_reg <= '0;
					end
				end
				ASRC_LEFT: begin
					// both channels accumulate with the same coefficient each tap
					acc_l_reg <= acc_l_reg + prod_l;
					acc_r_reg <= acc_r_reg + prod_r;
					raddr_reg <= raddr_reg - 1'b1;
					ph_reg    <= ph_sum[FB+6:0];
				end
				ASRC_DONE: begin
					o_out_left  <= sat(acc_l_reg);
					o_out_right <= sat(acc_r_reg);
					o_out_valid <= 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// a convolution spans 64*stretch taps, finishing on phase wrap
	logic [10:0] tap_cnt_reg;
	always_ff @(posedge i_clk) begin
		if (i_srst || st_reg != ASRC_LEFT)
			tap_cnt_reg <= '0;
		else
			tap_cnt_reg <= tap_cnt_reg + 1'b1;
	end
	a_tap_bound: assert property (@(posedge i_clk) disable iff (i_srst)
		(st_reg == ASRC_LEFT) |-> tap_cnt_reg < 11'd512)
		else $error("convolution ran past buffer history");
	a_addr_step: assert property (@(posedge i_clk) disable iff (i_srst)
		(st_reg == ASRC_LEFT && $past(st_reg) == ASRC_LEFT) |->
		raddr_reg == $past(raddr_reg) - 1'b1)
		else $error("buffer address did not step down by one");
	a_done_valid: assert property (@(posedge i_clk) disable iff (i_srst)
		(st_reg == ASRC_DONE) |=> o_out_valid ##1 !o_out_valid)
		else $error("output valid not a single pulse after convolution");
	a_flag_fast: assert property (@(posedge i_clk) disable iff (i_srst)
		(i_out_strobe && step_diff[24:8] != '0 && step_diff[24:8] != '1)
		|=> o_servo_settling_flag)
		else $error("settling flag not raised on a large rate error");
	a_sat_range: assert property (@(posedge i_clk) disable iff (i_srst)
		(o_out_valid && acc_l_reg >>> (CW - 1) > ACC_W'(2**(DATA_W-1) - 1))
		|-> o_out_left == {1'b0, {(DATA_W-1){1'b1}}})
		else $error("overflow not saturated");
	a_lead_min: assert property (@(posedge i_clk) disable iff (i_srst)
		(st_reg == ASRC_IDLE && st_next == ASRC_LEFT) |->
		AW'(wr_reg - ramp_reg[AW+FB-1:FB]) != AW'(0))
		else $error("read start caught up with the write pointer");
	a_stretch_max: assert property (@(posedge i_clk) disable iff (i_srst)
		stretch <= 4'(MAXDEC) && stretch != 4'h0)
		else $error("stretch outside buffer-supported range");
	a_unity_step: assert property (@(posedge i_clk) disable iff (i_srst)
		!decim |-> ph_step == (FB+1)'(1 << FB))
		else $error("upsampling phase step not one full phase");
endmodule

// ===== dv/asrc_audio_partner.sv
// far-side audio model: stereo sample source and output-rate strobe
// assumes it shares the master clock and drives on its falling edge
`timescale 1ns/1ps
module asrc_audio_partner (
	input  wire logic                 i_clk,
	input  wire logic                 i_run,
	input  wire logic [15:0]          i_in_period,
	input  wire logic [15:0]          i_out_period,
	input  wire asrc_pkg::asrc_word_t i_level,
	input  wire logic                 i_ready,
	output logic                      o_valid,
	output asrc_pkg::asrc_word_t      o_left,
	output asrc_pkg::asrc_word_t      o_right,
	output logic                      o_strobe
);
	import asrc_pkg::*;
	logic [15:0] in_cnt;
	logic [15:0] out_cnt;
	int          pend;
	logic        took;
	initial begin
		in_cnt = 16'h0000;
		out_cnt = 16'h0000;
		pend = 0;
		took = 1'b0;
		o_valid = 1'b0;
		o_strobe = 1'b0;
		o_left = ~i_level;
		o_right = ~i_level;
	end
	// accept is judged at the sampling edge, acted on half a cycle later
	always @(posedge i_clk) took <= o_valid & i_ready;
	always @(negedge i_clk) begin
		if (took)
			pend = pend - 1;
		in_cnt = i_run ? in_cnt + 16'h0001 : 16'h0000;
		if (i_run && in_cnt >= i_in_period) begin
			in_cnt = 16'h0000;
			pend = pend + 1;
		end
		o_valid = pend > 0;
		// an idle data bus shows the inverse, so a stale capture is caught
		o_left = o_valid ? i_level : ~i_level;
		o_right = o_valid ? i_level : ~i_level;
		out_cnt = (i_run && i_out_period != 16'h0000) ? out_cnt + 16'h0001 : 16'h0000;
		o_strobe = i_run && i_out_period != 16'h0000 && out_cnt >= i_out_period;
		if (o_strobe)
			out_cnt = 16'h0000;
	end
endmodule

// ===== dv/testbench.sv
// self-checking bench for the sample rate converter core
// assumes the far-side model in asrc_audio_partner.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module testbench;
	import asrc_pkg::*;
	logic       i_clk;
	logic       i_srst;
	logic       run;
	logic [15:0] in_p;
	logic [15:0] out_p;
	asrc_word_t level;
	logic       in_valid;
	logic       in_ready;
	logic       strobe;
	logic       out_valid;
	logic       flag;
	asrc_word_t in_l;
	asrc_word_t in_r;
	asrc_word_t out_l;
	asrc_word_t out_r;
	logic       st;
	logic       ov;
	logic       rdy;
	logic       seen_full;
	logic       seen_flag;
	int         err_count;
	int         comparisons;
	int         cycles;
	int         lat;
	int         min_lat;
	int         valids;
	int         nstb;
	asrc_audio_partner i_far (.i_clk(i_clk), .i_run(run), .i_in_period(in_p),
		.i_out_period(out_p), .i_level(level), .i_ready(in_ready), .o_valid(in_valid),
		.o_left(in_l), .o_right(in_r), .o_strobe(strobe));
	asrc_core i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_in_valid(in_valid),
		.o_in_ready(in_ready), .i_in_left(in_l), .i_in_right(in_r), .i_out_strobe(strobe),
		.i_group_delay(7'h05), .o_out_left(out_l), .o_out_right(out_r),
		.o_out_valid(out_valid), .o_servo_settling_flag(flag));
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	// sample at the rising edge, book-keep at the falling edge: no race
	always @(posedge i_clk) begin
		st <= strobe;
		ov <= out_valid;
		rdy <= in_ready;
	end
	always @(negedge i_clk) begin
		cycles++;
		lat = st ? 0 : lat + 1;
		nstb = nstb + int'(st);
		if (!rdy)
			seen_full = 1'b1;
		if (flag)
			seen_flag = 1'b1;
		if (ov) begin
			valids++;
			if (lat < min_lat)
				min_lat = lat;
		end
		if (cycles > 95000) begin
			err_count++;
			results();
		end
	end
	task results;
		if (err_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// warm up for n strobes, then gather statistics over n more
	task phase(input int ip, input int op, input asrc_word_t lv, input int n);
		in_p = ip[15:0];
		out_p = op[15:0];
		level = lv;
		run = 1'b1;
		repeat (n * op) @(negedge i_clk);
		min_lat = 999;
		valids = 0;
		nstb = 0;
		seen_flag = 1'b0;
		repeat (n * op) @(negedge i_clk);
	endtask
	task t_reset;
		`CHK({out_l, out_r, ov, rdy, flag}, {48'h0, 3'b011})
	endtask
	// engine busy means the fifo cannot drain: fill until refused, then drain
	task t_fill;
		seen_full = 1'b0;
		in_p = 16'h0002;
		out_p = 16'h012C;
		level = 24'h123456;
		run = 1'b1;
		repeat (450) @(negedge i_clk);
		`CHK(seen_full, 1'b1)
		run = 1'b0;
		repeat (600) @(negedge i_clk);
		`CHK(rdy, 1'b1)
	endtask
	task t_upsample;
		phase(100, 75, 24'h7FFFFF, 100);
		`CHK(min_lat >= 65 && min_lat <= 69, 1'b1)
		`CHK(valids >= nstb - 1 && valids <= nstb, 1'b1)
		`CHK(out_l[23], 1'b0)
		`CHK(out_l, out_r)
		`CHK(flag, 1'b0)
	endtask
	task t_negative;
		phase(100, 75, 24'h800000, 60);
		`CHK(out_l[23], 1'b1)
		`CHK(out_l, out_r)
	endtask
	// in/out ratio 2.5 gives stretch 2: about 128 taps per result
	task t_decim;
		run = 1'b0;
		seen_flag = 1'b0;
		in_p = 16'h003C;
		out_p = 16'h0096;
		level = 24'h100000;
		run = 1'b1;
		repeat (2000) @(negedge i_clk);
		`CHK(seen_flag, 1'b1)
		phase(60, 150, 24'h100000, 75);
		`CHK(min_lat >= 129 && min_lat <= 133, 1'b1)
		`CHK(valids >= nstb - 1 && valids <= nstb, 1'b1)
		`CHK(out_l, out_r)
		`CHK(flag, 1'b0)
	endtask
	initial begin
		i_srst = 1'b1;
		run = 1'b0;
		in_p = 16'h0000;
		out_p = 16'h0000;
		level = 24'h000000;
		err_count = 0;
		comparisons = 0;
		cycles = 0;
		lat = 0;
		min_lat = 999;
		valids = 0;
		nstb = 0;
		seen_full = 1'b0;
		seen_flag = 1'b0;
		repeat (6) @(negedge i_clk);
		t_reset();
		i_srst = 1'b0;
		t_fill();
		t_upsample();
		t_negative();
		t_decim();
		results();
	end
endmodule
